// [logic/smpa_defs.svh]
`ifndef SMPA_DEFS_SVH
`define SMPA_DEFS_SVH

// register byte offsets on the apb slave
`define SMPA_ADDR_ISR_PR 8'h00
`define SMPA_ADDR_MAIN_PR 8'h04
`define SMPA_ADDR_DMA1_PR 8'h08
`define SMPA_ADDR_DMA2_PR 8'h0C
`define SMPA_ADDR_SCAN_PR 8'h10
`define SMPA_ADDR_LOCK 8'h14
`define SMPA_ADDR_STATUS 8'h18

// priority reset values
`define SMPA_RST_ISR_PR 3'h0
`define SMPA_RST_MAIN_PR 3'h1
`define SMPA_RST_DMA1_PR 3'h2
`define SMPA_RST_DMA2_PR 3'h3
`define SMPA_RST_SCAN_PR 3'h4

// requester indices, also the tie-break order
`define SMPA_IDX_ISR 3'h0
`define SMPA_IDX_MAIN 3'h1
`define SMPA_IDX_DMA1 3'h2
`define SMPA_IDX_DMA2 3'h3
`define SMPA_IDX_SCAN 3'h4
`define SMPA_IDX_LOCK 3'h5
`define SMPA_IDX_STATUS 3'h6
`define SMPA_IDX_NONE 3'h7

// lock register keys and field
`define SMPA_UNLOCK_KEY1 8'h55
`define SMPA_UNLOCK_KEY2 8'hAA
`define SMPA_LOCK_BIT 0

// status register fields
`define SMPA_ST_LOCK 0
`define SMPA_ST_STALL 1
`define SMPA_ST_OWNED 2
`define SMPA_ST_ONEWAY 3
`define SMPA_ST_OWNER_LSB 4
`define SMPA_ST_OWNER_MSB 5

`endif

// [logic/smpa_pkg.sv]
package smpa_pkg;
  typedef enum logic [1:0] {SMPA_TGT_FLASH, SMPA_TGT_REGFILE, SMPA_TGT_EEPROM} smpa_target_t;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_KEY1, SEQ_ARMED} smpa_seq_t;
  typedef logic [2:0] smpa_prio_t;
endpackage

// [logic/smpa_lock_seq.sv]
`timescale 1ns/1ps
`include "smpa_defs.svh"
module smpa_lock_seq
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic lock_wr,
  input wire logic other_wr,
  input wire logic [7:0] wr_data,
  input wire logic one_way_lock_option,
  output logic priority_lock_bit,
  output logic one_way_reg
);
  import smpa_pkg::*;

  smpa_seq_t seq_reg;
  smpa_seq_t seq_next;
  logic lock_next;
  logic strap_taken_reg;

  always_comb
  begin
    seq_next = seq_reg;
    lock_next = priority_lock_bit;
    case (seq_reg)
      SEQ_IDLE:
      begin
        if (lock_wr && wr_data == `SMPA_UNLOCK_KEY1)
          seq_next = SEQ_KEY1;
      end
      SEQ_KEY1:
      begin
        if (lock_wr && wr_data == `SMPA_UNLOCK_KEY2)
          seq_next = SEQ_ARMED;
        else if (lock_wr || other_wr)
          seq_next = SEQ_IDLE;
      end
      SEQ_ARMED:
      begin
        if (lock_wr)
        begin
          seq_next = SEQ_IDLE;
          // one-way mode: a set sticks until system reset
          if (wr_data[`SMPA_LOCK_BIT] || !one_way_reg)
            lock_next = wr_data[`SMPA_LOCK_BIT];
        end
        else if (other_wr)
          seq_next = SEQ_IDLE;
      end
      default: seq_next = SEQ_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      seq_reg <= SEQ_IDLE;
      priority_lock_bit <= 1'b0;
    end
    else
    begin
      seq_reg <= seq_next;
      priority_lock_bit <= lock_next;
    end
  end

  // strap caught once, on the first edge after release
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      strap_taken_reg <= 1'b0;
      one_way_reg <= 1'b0;
    end
    else if (!strap_taken_reg)
    begin
      strap_taken_reg <= 1'b1;
      one_way_reg <= one_way_lock_option;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_lock_needs_seq: assert property ($changed(priority_lock_bit) |-> $past(seq_reg == SEQ_ARMED && lock_wr))
    else $error("lock bit changed outside the unlock sequence");
  a_one_way_sticks: assert property (one_way_reg && priority_lock_bit |=> priority_lock_bit)
    else $error("lock bit cleared in one-way mode");
endmodule

// [logic/smpa_arbiter.sv]
`timescale 1ns/1ps
`include "smpa_defs.svh"
//Contract
// - arbitrate five requesters by their programmed priority values.
// - smaller priority number wins; 0 highest, 7 lowest.
// - reset priorities: isr 0, main 1, dma1 2, dma2 3, scanner 4.
// - dma channels and scanner get memory only while lock bit set; an owning upper peripheral keeps its grant after a clear.
// - while locked, priority writes are ignored.
// - lock bit changes only right after the 55h, AAh key writes.
// - with lock cleared, priority writes take effect.
// - lower peripheral uses flash only in cpu-free, flash-idle cycles.
// - lower peripheral uses register file only when cpu does not.
// - lower peripheral uses eeprom whenever no eeprom operation runs.
// - lower peripherals never stall the cpu.
// - higher peripheral stalls cpu until its operation finishes.
// - an owning higher peripheral keeps the bus until done.
// - isr outranking a peripheral preempts it; peripheral still stalls main.
// - lower peripheral may use cycles an upper owner leaves unused.
// - one-way option: lock cannot clear after set until reset.
module smpa_arbiter
#(
  parameter int ADDR_W = 8
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic one_way_lock_option,
  input wire logic cpu_isr_active,
  input wire logic cpu_flash_access,
  input wire logic cpu_rf_access,
  input wire logic flash_op_busy,
  input wire logic eeprom_op_busy,
  input wire logic [2:0] per_req,
  input wire smpa_pkg::smpa_target_t dma1_target,
  input wire smpa_pkg::smpa_target_t dma2_target,
  input wire smpa_pkg::smpa_target_t scan_target,
  input wire logic [2:0] per_done,
  output logic [2:0] per_grant,
  output smpa_pkg::smpa_target_t grant_target,
  output logic cpu_stall,
  output logic priority_lock_bit
);
  import smpa_pkg::*;

  if (ADDR_W < 8)
    $error("ADDR_W too small for the register map");

  smpa_prio_t prio_reg [0:4];
  logic one_way_reg;
  logic [2:0] owner_reg;
  logic owner_valid_reg;
  logic first_reg;
  logic [2:0] rd_idx;
  logic [2:0] wr_idx;
  logic wr_en;
  logic lock_wr;
  logic other_wr;
  smpa_target_t tgt [0:2];
  smpa_prio_t ctx_pr;
  logic [2:0] ctx_idx;
  logic [2:0] above;
  logic [2:0] freed;
  logic owner_live;
  logic owner_up;
  logic up_found;
  logic [1:0] up_sel;
  logic lo_found;
  logic [1:0] lo_sel;
  logic [2:0] grant_next;
  smpa_target_t gtgt_next;
  logic stall_next;
  logic owner_valid_next;
  logic [1:0] owner_next;

  function automatic logic [2:0] decode(input logic [ADDR_W-1:0] a);
    logic [7:0] lo;
    lo = a[7:0];
    if ((a >> 8) != '0)
      return `SMPA_IDX_NONE;
    case (lo)
      `SMPA_ADDR_ISR_PR: return `SMPA_IDX_ISR;
      `SMPA_ADDR_MAIN_PR: return `SMPA_IDX_MAIN;
      `SMPA_ADDR_DMA1_PR: return `SMPA_IDX_DMA1;
      `SMPA_ADDR_DMA2_PR: return `SMPA_IDX_DMA2;
      `SMPA_ADDR_SCAN_PR: return `SMPA_IDX_SCAN;
      `SMPA_ADDR_LOCK: return `SMPA_IDX_LOCK;
      `SMPA_ADDR_STATUS: return `SMPA_IDX_STATUS;
      default: return `SMPA_IDX_NONE;
    endcase
  endfunction

  // a beats b; equal values fall back to fixed index order
  function automatic logic urgent(input smpa_prio_t pa, input logic [2:0] ia,
                                  input smpa_prio_t pb, input logic [2:0] ib);
    return (pa < pb) || (pa == pb && ia < ib);
  endfunction

  function automatic smpa_prio_t rst_prio(input int i);
    case (i)
      0: return `SMPA_RST_ISR_PR;
      1: return `SMPA_RST_MAIN_PR;
      2: return `SMPA_RST_DMA1_PR;
      3: return `SMPA_RST_DMA2_PR;
      default: return `SMPA_RST_SCAN_PR;
    endcase
  endfunction

  assign rd_idx = decode(paddr);
  assign wr_idx = rd_idx;
  assign wr_en = psel && penable && pwrite && pready;
  assign lock_wr = wr_en && wr_idx == `SMPA_IDX_LOCK;
  assign other_wr = wr_en && wr_idx != `SMPA_IDX_LOCK;
  assign tgt[0] = dma1_target;
  assign tgt[1] = dma2_target;
  assign tgt[2] = scan_target;

  smpa_lock_seq u_lock
  (
    .pclk(pclk),
    .presetn(presetn),
    .lock_wr(lock_wr),
    .other_wr(other_wr),
    .wr_data(pwdata[7:0]),
    .one_way_lock_option(one_way_lock_option),
    .priority_lock_bit(priority_lock_bit),
    .one_way_reg(one_way_reg)
  );

  // no wait state: pready rises with the access phase, read data ready with it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else if (psel && !penable)
    begin
      pready <= 1'b1;
      pslverr <= (rd_idx == `SMPA_IDX_NONE);
      prdata <= 32'h00000000;
      if (rd_idx <= `SMPA_IDX_SCAN)
        prdata[2:0] <= prio_reg[rd_idx];
      else if (rd_idx == `SMPA_IDX_LOCK)
        prdata[`SMPA_LOCK_BIT] <= priority_lock_bit;
      else if (rd_idx == `SMPA_IDX_STATUS)
      begin
        prdata[`SMPA_ST_LOCK] <= priority_lock_bit;
        prdata[`SMPA_ST_STALL] <= cpu_stall;
        prdata[`SMPA_ST_OWNED] <= owner_valid_reg;
        prdata[`SMPA_ST_ONEWAY] <= one_way_reg;
        prdata[`SMPA_ST_OWNER_MSB:`SMPA_ST_OWNER_LSB] <= owner_reg[1:0];
      end
    end
    else
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < 5; i++)
        prio_reg[i] <= rst_prio(i);
    end
    else if (wr_en && !priority_lock_bit && wr_idx <= `SMPA_IDX_SCAN)
      prio_reg[wr_idx] <= pwdata[2:0];
  end

  always_comb
  begin
    ctx_pr = cpu_isr_active ? prio_reg[`SMPA_IDX_ISR] : prio_reg[`SMPA_IDX_MAIN];
    ctx_idx = cpu_isr_active ? `SMPA_IDX_ISR : `SMPA_IDX_MAIN;
    owner_live = owner_valid_reg && !per_done[owner_reg[1:0]];
    for (int p = 0; p < 3; p++)
    begin
      // an owner keeps its rank even if software drops the lock mid-operation
      above[p] = urgent(prio_reg[p+2], 3'(p + 2), ctx_pr, ctx_idx)
                 && (priority_lock_bit || (owner_live && owner_reg == 3'(p)));
    end
    owner_up = owner_live && above[owner_reg[1:0]];
    up_found = owner_up;
    up_sel = owner_reg[1:0];
    if (!owner_up)
    begin
      for (int p = 0; p < 3; p++)
      begin
        if (per_req[p] && above[p]
            && (!up_found || urgent(prio_reg[p+2], 3'(p + 2), prio_reg[up_sel+2], 3'(up_sel) + 3'h2)))
        begin
          up_found = 1'b1;
          up_sel = 2'(p);
        end
      end
    end
    // a stalled cpu makes no flash or register-file access of its own
    for (int p = 0; p < 3; p++)
    begin
      case (tgt[p])
        SMPA_TGT_FLASH: freed[p] = !flash_op_busy && (up_found || !cpu_flash_access);
        SMPA_TGT_REGFILE: freed[p] = up_found || !cpu_rf_access;
        SMPA_TGT_EEPROM: freed[p] = !eeprom_op_busy;
        default: freed[p] = 1'b0;
      endcase
    end
    lo_found = 1'b0;
    lo_sel = 2'h0;
    for (int p = 0; p < 3; p++)
    begin
      if (per_req[p] && priority_lock_bit && freed[p] && !(up_found && up_sel == 2'(p))
          && (!lo_found || urgent(prio_reg[p+2], 3'(p + 2), prio_reg[lo_sel+2], 3'(lo_sel) + 3'h2)))
      begin
        lo_found = 1'b1;
        lo_sel = 2'(p);
      end
    end
    grant_next = 3'h0;
    gtgt_next = grant_target;
    stall_next = up_found;
    if (up_found && per_req[up_sel])
    begin
      grant_next[up_sel] = 1'b1;
      gtgt_next = tgt[up_sel];
    end
    else if (lo_found)
    begin
      grant_next[lo_sel] = 1'b1;
      gtgt_next = tgt[lo_sel];
    end
    owner_valid_next = owner_live || up_found;
    owner_next = owner_live ? owner_reg[1:0] : up_sel;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      per_grant <= 3'h0;
      grant_target <= SMPA_TGT_FLASH;
      cpu_stall <= 1'b0;
    end
    else
    begin
      per_grant <= grant_next;
      grant_target <= gtgt_next;
      cpu_stall <= stall_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      owner_valid_reg <= 1'b0;
      owner_reg <= 3'h0;
    end
    else
    begin
      owner_valid_reg <= owner_valid_next;
      owner_reg <= {1'b0, owner_next};
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      first_reg <= 1'b1;
    else
      first_reg <= 1'b0;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_owned;
    owner_valid_reg && !per_done[owner_reg[1:0]];
  endsequence

  sequence s_keep_owner;
    owner_valid_reg && $stable(owner_reg);
  endsequence

  a_reset_prio: assert property (first_reg |-> prio_reg[0] == `SMPA_RST_ISR_PR
    && prio_reg[1] == `SMPA_RST_MAIN_PR && prio_reg[2] == `SMPA_RST_DMA1_PR
    && prio_reg[3] == `SMPA_RST_DMA2_PR && prio_reg[4] == `SMPA_RST_SCAN_PR)
    else $error("priorities not at reset values");
  a_locked_prio_hold: assert property (wr_en && priority_lock_bit |=> $stable(prio_reg[0])
    && $stable(prio_reg[1]) && $stable(prio_reg[2]) && $stable(prio_reg[3]) && $stable(prio_reg[4]))
    else $error("priority changed while locked");
  a_unlocked_prio_write: assert property (wr_en && !priority_lock_bit && wr_idx == `SMPA_IDX_DMA1
    |=> prio_reg[2] == $past(pwdata[2:0]))
    else $error("priority write lost while unlocked");
  a_single_grant: assert property ($onehot0(per_grant))
    else $error("more than one peripheral granted");
  a_grant_needs_lock: assert property (|per_grant |-> $past(priority_lock_bit || owner_valid_reg))
    else $error("peripheral granted without lock");
  a_steal_flash: assert property (|per_grant && !cpu_stall && grant_target == SMPA_TGT_FLASH
    |-> $past(!cpu_flash_access && !flash_op_busy))
    else $error("flash stolen from a busy cycle");
  a_steal_regfile: assert property (|per_grant && !cpu_stall && grant_target == SMPA_TGT_REGFILE
    |-> $past(!cpu_rf_access))
    else $error("register file stolen from cpu");
  a_steal_eeprom: assert property (|per_grant && !cpu_stall
    && grant_target == SMPA_TGT_EEPROM |-> $past(!eeprom_op_busy))
    else $error("eeprom granted during an eeprom operation");
  a_owner_kept: assert property (s_owned |=> s_keep_owner)
    else $error("owner lost before done");
  a_owner_stalls: assert property (s_owned and (priority_lock_bit && !cpu_isr_active
    && urgent(prio_reg[owner_reg[1:0]+2], owner_reg + 3'h2, prio_reg[1], `SMPA_IDX_MAIN))
    |=> cpu_stall)
    else $error("cpu not stalled for owning peripheral");
  a_isr_preempts: assert property (cpu_isr_active && prio_reg[0] < prio_reg[2]
    && prio_reg[0] < prio_reg[3] && prio_reg[0] < prio_reg[4] |=> !cpu_stall)
    else $error("isr did not preempt peripheral");
endmodule

// [bench/smpa_far_model.sv]
`timescale 1ns/1ps
module smpa_far_model
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  input wire logic [1:0] ch,
  input wire logic [2:0] len,
  input wire logic [2:0] per_grant,
  output logic [2:0] per_req,
  output logic [2:0] per_done
);
  logic [2:0] cnt;

  // one peripheral at a time; it counts granted accesses, never gives up early
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      per_req <= 3'h0;
      per_done <= 3'h0;
      cnt <= 3'h0;
    end
    else
    begin
      per_done <= 3'h0;
      if (go && per_req == 3'h0)
      begin
        per_req <= 3'h1 << ch;
        cnt <= len;
      end
      else if ((per_grant & per_req) != 3'h0)
      begin
        cnt <= cnt - 3'h1;
        if (cnt == 3'h1)
        begin
          per_done <= per_req;
          per_req <= 3'h0;
        end
      end
    end
  end
endmodule

// [bench/smpa_arbiter_tb.sv]
`timescale 1ns/1ps
`include "smpa_defs.svh"
module smpa_arbiter_tb;
  import smpa_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, er, cpu_stall, lock;
  logic one_way = 1'b0;
  logic isr_act = 1'b0;
  logic cfl = 1'b0;
  logic crf = 1'b0;
  logic fbusy = 1'b0;
  logic ebusy = 1'b0;
  logic go = 1'b0;
  logic lk = 1'b0;
  logic [1:0] ch = 2'h0;
  logic [2:0] len = 3'h1;
  logic [2:0] per_req, per_done, per_grant;
  logic [2:0] pr [5];
  logic [2:0] cfgs [3][5] = '{'{3'h0, 3'h1, 3'h2, 3'h3, 3'h4},
    '{3'h3, 3'h4, 3'h0, 3'h1, 3'h2}, '{3'h0, 3'h4, 3'h1, 3'h2, 3'h3}};
  smpa_target_t tgt = SMPA_TGT_FLASH;
  smpa_target_t grant_target;
  logic [31:0] rnd = 32'hA1CE;
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;

  smpa_arbiter smpa_arbiter_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .one_way_lock_option(one_way),
    .cpu_isr_active(isr_act), .cpu_flash_access(cfl), .cpu_rf_access(crf),
    .flash_op_busy(fbusy), .eeprom_op_busy(ebusy), .per_req(per_req), .dma1_target(tgt),
    .dma2_target(tgt), .scan_target(tgt), .per_done(per_done), .per_grant(per_grant),
    .grant_target(grant_target), .cpu_stall(cpu_stall), .priority_lock_bit(lock));

  smpa_far_model smpa_far_model_inst (.pclk(pclk), .presetn(presetn), .go(go), .ch(ch),
    .len(len), .per_grant(per_grant), .per_req(per_req), .per_done(per_done));

  always #4 pclk = ~pclk;

  task stop_test;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      stop_test();
    end
  end

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      $display("Error %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  // entered just after a rising edge, leaves one edge after release
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task lock_set(input logic v);
    apb(1'b1, `SMPA_ADDR_LOCK, 32'h55);
    apb(1'b1, `SMPA_ADDR_LOCK, 32'hAA);
    apb(1'b1, `SMPA_ADDR_LOCK, {31'h0, v});
    lk = v;
  endtask

  // expectation per cycle from the inputs the arbiter samples at that edge
  task run(input int n, input logic ge, input logic eb);
    logic [2:0] cp, ctx, eg;
    logic fr, up, es, iss;
    repeat (n)
    begin
      @(posedge pclk);
      cp = per_req[0] ? pr[2] : per_req[1] ? pr[3] : pr[4];
      ctx = isr_act ? pr[0] : pr[1];
      up = cp < ctx;
      fr = tgt == SMPA_TGT_FLASH ? !cfl && !fbusy : tgt == SMPA_TGT_REGFILE ? !crf : !ebusy;
      es = lk && per_req != 3'h0 && up;
      eg = (lk && per_req != 3'h0 && (up || fr)) ? per_req : 3'h0;
      rnd = xs(rnd);
      iss = ge && per_req == 3'h0 && !go && rnd[5];
      isr_act <= rnd[0];
      cfl <= rnd[1];
      crf <= rnd[2];
      fbusy <= rnd[3];
      ebusy <= rnd[4] && eb;
      go <= iss;
      if (iss)
      begin
        ch <= 2'(rnd[7:6] % 3);
        len <= {1'b0, rnd[9:8]} + 3'h1;
        tgt <= smpa_target_t'(rnd[11:10] % 3);
      end
      @(negedge pclk);
      chk("per_grant", {29'h0, eg}, {29'h0, per_grant});
      chk("cpu_stall", {31'h0, es}, {31'h0, cpu_stall});
      if (eg != 3'h0)
        chk("grant_target", {30'h0, tgt}, {30'h0, grant_target});
    end
    @(posedge pclk);
  endtask

  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b0, `SMPA_ADDR_ISR_PR + 8'(4 * i), 32'h0);
      chk("prio_reset", 32'(i), rd);
    end
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, er});
    apb(1'b1, `SMPA_ADDR_LOCK, 32'h55);
    apb(1'b1, `SMPA_ADDR_LOCK, 32'h56);
    apb(1'b1, `SMPA_ADDR_LOCK, 32'h1);
    chk("lock_bad_key", 32'h0, {31'h0, lock});
    for (int c = 0; c < 3; c++)
    begin
      for (int i = 0; i < 5; i++)
      begin
        pr[i] = cfgs[c][i];
        apb(1'b1, `SMPA_ADDR_ISR_PR + 8'(4 * i), {29'h0, pr[i]});
        apb(1'b0, `SMPA_ADDR_ISR_PR + 8'(4 * i), 32'h0);
        chk("prio_write", {29'h0, pr[i]}, rd);
      end
      run(30, 1'b1, 1'b0);
      lock_set(1'b1);
      chk("lock_set", 32'h1, {31'h0, lock});
      apb(1'b1, `SMPA_ADDR_DMA1_PR, 32'h7);
      apb(1'b0, `SMPA_ADDR_DMA1_PR, 32'h0);
      chk("prio_locked", {29'h0, pr[2]}, rd);
      run(300, 1'b1, c == 0);
      // drain first: an owner keeps its rank across an unlock
      while (per_req != 3'h0 || go)
        run(1, 1'b0, 1'b0);
      lock_set(1'b0);
      chk("lock_clear", 32'h0, {31'h0, lock});
    end
    presetn <= 1'b0;
    one_way <= 1'b1;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    lock_set(1'b1);
    lock_set(1'b0);
    chk("lock_one_way", 32'h1, {31'h0, lock});
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("lock_after_reset", 32'h0, {31'h0, lock});
    presetn <= 1'b1;
    @(posedge pclk);
    lock_set(1'b1);
    chk("lock_reset_again", 32'h1, {31'h0, lock});
    apb(1'b0, `SMPA_ADDR_STATUS, 32'h0);
    chk("status", (32'h1 << `SMPA_ST_LOCK) | (32'h1 << `SMPA_ST_ONEWAY), rd);
    stop_test();
  end
endmodule
